// >>> src/pmu_alarm_regs.sv
// Register bank of a two-channel per-pin measurement unit, with alarm latching and the
// serial programming port that reaches it.
// Assumes serial pins and analog status flags arrive asynchronously to clk_sys.
`timescale 1ns/10ps

// Three-stage synchroniser; the output only moves when stages two and three agree
module pmu_sync3 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] RST  = '0,   // Idle level of each input, so no false edge after reset
    parameter bit           WORD = 1'b0  // 1: the whole word moves at once, never a bit mix
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_reg;   // Metastability catcher, read only by s2
    logic [W-1:0] s2_reg;   // Second stage
    logic [W-1:0] s3_reg;   // Third stage

    // Shift chain
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= RST;
            s2_reg <= RST;
            s3_reg <= RST;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept only when the two late stages agree, which filters one-cycle glitches.
    // Word mode waits for every bit, so a changing value is never seen half old, half new;
    // the cost is that a word that never settles is never taken.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dout <= RST;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (WORD ? (s2_reg == s3_reg) : (s2_reg[i] == s3_reg[i])) begin
                    dout[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

module pmu_alarm_regs #(
    parameter logic [31:0] SERIAL_CODE = 32'h1234_5678 // Arbitrary value
) (
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire pmu_pkg::pmu_spi_in_t spi_in,
    output logic                     sdo_o,
    output logic                     sdo_oe,
    input  wire logic [7:0]          temp_celsius,
    input  wire logic [1:0]          clamp_engaged,
    input  wire logic [1:0]          overvoltage_fault,
    output logic                     alarm_o,
    output logic                     alarm_oe,
    output pmu_pkg::pmu_ctrl_t [1:0] unit_ctrl,
    output logic [1:0]               meas_out_oe,
    output logic [1:0]               meas_out_temp_sel,
    output logic [1:0]               voltage_clamp_on
);
    import pmu_pkg::*;

    pmu_spi_in_t      spi_s;            // Synchronised serial pins
    logic [7:0]       temp_s;           // Synchronised temperature
    logic [1:0]       clamp_s;          // Synchronised clamp flags
    logic [1:0]       ovd_s;            // Synchronised overvoltage flags
    logic             sclk_d_reg;       // Last serial clock level
    logic [4:0]       bit_cnt_reg;      // Rising edges seen in this frame
    logic [25:0]      shift_reg;        // Received bits, first bit ends up on top
    logic [9:0]       hdr_reg;          // Frame header, frozen once index 9 is in
    pmu_ctrl_t  [1:0] ctrl_reg;         // Unit control registers
    pmu_alarm_t [1:0] alarm_reg;        // Alarm mask registers
    logic [1:0]       clamp_lat_reg;    // Latched clamp alarm per channel
    logic [1:0]       ovd_lat_reg;      // Latched overvoltage alarm per channel
    logic             sdo_reg;          // Serial output bit
    logic             sclk_rise;        // Serial clock rising edge, frame open
    logic             sclk_fall;        // Serial clock falling edge, frame open
    logic             commit;           // Last bit of a write frame arrives
    logic [25:0]      frame;            // Whole frame at commit
    logic [1:0]       wr_ctrl;          // Per channel control write
    logic [1:0]       wr_alarm;         // Per channel alarm write
    logic [15:0]      rd_word;          // Word returned on a read
    logic [7:0]       thr_c;            // Selected thermal threshold
    logic             therm_hot;        // Over-temperature and enabled

    // Bring asynchronous pins into the clock domain
    // Serial pins reset to their idle levels: deselected, clock low, data low
    pmu_sync3 #(.W(3), .RST(3'h4)) u_sync_spi (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .din     (spi_in),
        .dout    (spi_s)
    );
    // Temperature is a word, so it crosses whole; the fault flags cross bit by bit so a
    // restless temperature can never hold back a fault
    pmu_sync3 #(.W(8), .WORD(1'b1)) u_sync_temp (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .din     (temp_celsius),
        .dout    (temp_s)
    );
    pmu_sync3 #(.W(4)) u_sync_flag (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .din     ({clamp_engaged, overvoltage_fault}),
        .dout    ({clamp_s, ovd_s})
    );

    assign sclk_rise = !spi_s.cs_n && spi_s.sclk && !sclk_d_reg;
    assign sclk_fall = !spi_s.cs_n && !spi_s.sclk && sclk_d_reg;

    // Whole frame as it stands when its last bit is sampled
    assign frame  = {shift_reg[24:0], spi_s.sdi};
    assign commit = sclk_rise && (bit_cnt_reg == PMU_IDX_LAST) && !frame[25 - PMU_IDX_RW];

    // Write strobes; the header may address both channels at once
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            wr_ctrl[c]  = commit && frame[25 - int'(PMU_IDX_CH0) - c]
                          && (frame[25 - PMU_IDX_ADDR_HI -: 5] == PMU_ADDR_CTRL);
            wr_alarm[c] = commit && frame[25 - int'(PMU_IDX_CH0) - c]
                          && (frame[25 - PMU_IDX_ADDR_HI -: 5] == PMU_ADDR_ALARM);
        end
    end

    // Serial clock edge detect and bit counter; deselect restarts the frame
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d_reg  <= 1'b0;
            bit_cnt_reg <= 5'd0;
        end else begin
            sclk_d_reg <= spi_s.sclk;
            if (spi_s.cs_n) begin
                bit_cnt_reg <= 5'd0;
            end else if (sclk_rise && bit_cnt_reg != PMU_FRAME_BITS) begin
                // Extra clocks past the frame are ignored
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
            end
        end
    end

    // Receive shifter, most significant bit first
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= '0;
        end else if (sclk_rise && bit_cnt_reg != PMU_FRAME_BITS) begin
            shift_reg <= frame;
        end
    end

    // Header capture; the shifter keeps moving during a read, so the command, channel and
    // address bits are frozen here when the tenth bit arrives and serve the whole data phase
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hdr_reg <= 10'h000;
        end else if (sclk_rise && bit_cnt_reg == PMU_IDX_DATA_LO - 5'd1) begin
            hdr_reg <= frame[9:0];
        end
    end

    // Unit control registers; reserved bits never store
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= {PMU_CTRL_RESET, PMU_CTRL_RESET};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_ctrl[c]) begin
                    ctrl_reg[c] <= frame[15:0] & PMU_CTRL_WMASK;
                end
            end
        end
    end

    // Alarm mask registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alarm_reg <= {PMU_ALARM_RESET, PMU_ALARM_RESET};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_alarm[c]) begin
                    alarm_reg[c] <= frame[15:0] & PMU_ALARM_WMASK;
                end
            end
        end
    end

    // Threshold lookup from channel 0 only; each of the eight codes has a named value
    always_comb begin
        unique case (alarm_reg[0].thermal_threshold)
            3'h0: thr_c = PMU_THR_C0;
            3'h1: thr_c = PMU_THR_C1;
            3'h2: thr_c = PMU_THR_C2;
            3'h3: thr_c = PMU_THR_C3;
            3'h4: thr_c = PMU_THR_C4;
            3'h5: thr_c = PMU_THR_C5;
            3'h6: thr_c = PMU_THR_C6;
            3'h7: thr_c = PMU_THR_C7;
        endcase
    end

    // Thermal alarm is a level: it follows the temperature and is not latched
    assign therm_hot = !alarm_reg[0].thermal_alarm_mask && (temp_s > thr_c);

    // Clamp and overvoltage latches; a write to the channel's alarm register clears them,
    // but a fault present in that same cycle wins so no event is lost
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clamp_lat_reg <= 2'h0;
            ovd_lat_reg   <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (clamp_s[c] && !alarm_reg[c].clamp_alarm_mask) begin
                    clamp_lat_reg[c] <= 1'b1;
                end else if (wr_alarm[c]) begin
                    clamp_lat_reg[c] <= 1'b0;
                end
                if (ovd_s[c] && !alarm_reg[c].overvoltage_alarm_mask) begin
                    ovd_lat_reg[c] <= 1'b1;
                end else if (wr_alarm[c]) begin
                    ovd_lat_reg[c] <= 1'b0;
                end
            end
        end
    end

    // Open-drain fault pin: pulled low while any alarm stands
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alarm_oe <= 1'b0;
        end else begin
            alarm_oe <= therm_hot || (|clamp_lat_reg) || (|ovd_lat_reg);
        end
    end
    assign alarm_o = 1'b0; // Constant; only the enable moves

    // Read word; channel 0 answers when both channels are addressed
    always_comb begin
        logic ch;
        ch = !hdr_reg[9 - PMU_IDX_CH0];
        unique case (hdr_reg[9 - PMU_IDX_ADDR_HI -: 5])
            PMU_ADDR_CTRL:   rd_word = ctrl_reg[ch];
            PMU_ADDR_ALARM:  rd_word = alarm_reg[ch];
            PMU_ADDR_SERIAL: rd_word = ch ? SERIAL_CODE[31:16] : SERIAL_CODE[15:0];
            default:         rd_word = 16'h0000;
        endcase
    end

    // Serial output changes on falling edges, MSB first during indexes 10 to 25
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sdo_reg <= 1'b0;
        end else if (spi_s.cs_n) begin
            sdo_reg <= 1'b0;
        end else if (sclk_fall && bit_cnt_reg >= PMU_IDX_DATA_LO && bit_cnt_reg <= PMU_IDX_LAST
                     && hdr_reg[9 - PMU_IDX_RW]) begin
            sdo_reg <= rd_word[4'(PMU_IDX_LAST - bit_cnt_reg)];
        end
    end

    // Serial output drives only inside a frame
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= !spi_s.cs_n;
        end
    end
    assign sdo_o = sdo_reg;

    // Registered copies toward the analog unit; measure type sits in bit 6 since the
    // printed position collides with the input select
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            unit_ctrl         <= {PMU_CTRL_RESET, PMU_CTRL_RESET};
            meas_out_oe       <= 2'h0;
            meas_out_temp_sel <= 2'h0;
            voltage_clamp_on  <= 2'h0;
        end else begin
            // Mode fields pass straight through
            unit_ctrl <= ctrl_reg;
            for (int c = 0; c < 2; c++) begin
                meas_out_oe[c]       <= ctrl_reg[c].measure_out_enable;
                meas_out_temp_sel[c] <= ctrl_reg[c].measure_out_source_select[0];
                voltage_clamp_on[c]  <= ctrl_reg[c].voltage_clamp_enable;
            end
        end
    end
endmodule

// >>> src/pmu_pkg.sv
// Constants, field layouts and carriers for the per-pin measurement unit register bank.
// Assumes a two-channel device reached through one serial programming port.
package pmu_pkg;

    // Register offsets as seen in the serial frame address field
    localparam logic [4:0]  PMU_ADDR_CTRL    = 5'h1c;
    localparam logic [4:0]  PMU_ADDR_ALARM   = 5'h1d;
    localparam logic [4:0]  PMU_ADDR_SERIAL  = 5'h1f;

    // Values after reset
    localparam logic [15:0] PMU_CTRL_RESET   = 16'h0000;
    localparam logic [15:0] PMU_ALARM_RESET  = 16'h0085;

    // Writable bits; all others are reserved and read as zero
    localparam logic [15:0] PMU_CTRL_WMASK   = 16'he7ff;
    localparam logic [15:0] PMU_ALARM_WMASK  = 16'h00ed;

    // Serial frame layout, counted in serial clock indexes
    localparam logic [4:0]  PMU_IDX_RW       = 5'd0;
    localparam logic [4:0]  PMU_IDX_CH0      = 5'd1;
    localparam logic [4:0]  PMU_IDX_CH1      = 5'd2;
    localparam logic [4:0]  PMU_IDX_ADDR_HI  = 5'd3;
    localparam logic [4:0]  PMU_IDX_DATA_LO  = 5'd10;
    localparam logic [4:0]  PMU_IDX_LAST     = 5'd25;
    localparam logic [4:0]  PMU_FRAME_BITS   = 5'd26;

    // Thermal threshold table in degrees Celsius, indexed by the 3-bit code
    localparam logic [7:0]  PMU_THR_C0       = 8'd0;
    localparam logic [7:0]  PMU_THR_C1       = 8'd25;
    localparam logic [7:0]  PMU_THR_C2       = 8'd50;
    localparam logic [7:0]  PMU_THR_C3       = 8'd75;
    localparam logic [7:0]  PMU_THR_C4       = 8'd100;
    localparam logic [7:0]  PMU_THR_C5       = 8'd125;
    localparam logic [7:0]  PMU_THR_C6       = 8'd150;
    localparam logic [7:0]  PMU_THR_C7       = 8'd150;

    // Unit control register, one per channel
    typedef struct packed {
        logic [1:0] measure_out_source_select; // Bit 0: 0 unit, 1 temperature sensor
        logic       measure_out_enable;        // 0 leaves the pin high impedance
        logic [1:0] rsvd_12_11;                // Reserved
        logic       voltage_clamp_enable;      // Voltage clamps only
        logic       sense_path_select;         // 0 internal, 1 external
        logic [1:0] unit_input_select;         // 00 gnd, 01 gnd+2.5V, 1x level converter
        logic       measure_type_select;       // 0 voltage, 1 current
        logic       force_type_select;         // 0 voltage, 1 current
        logic [2:0] current_range_select;      // 0xx 2uA .. 111 40mA
        logic       unit_standby;              // 1 standby
        logic       unit_power_enable;         // 1 full power
    } pmu_ctrl_t;

    // Alarm mask register; threshold and thermal mask matter on channel 0 only
    typedef struct packed {
        logic [7:0] rsvd_15_8;
        logic [2:0] thermal_threshold;
        logic       rsvd_4;
        logic       thermal_alarm_mask;        // 0 enables
        logic       clamp_alarm_mask;          // 0 enables
        logic       rsvd_1;
        logic       overvoltage_alarm_mask;    // 0 enables
    } pmu_alarm_t;

    // Serial port pins as seen by the device
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } pmu_spi_in_t;

endpackage

// >>> dv/pmu_alarm_regs_asserts.sv
// Checker for the measurement unit register bank, watching top-level ports only.
// Assumes one clk_sys domain and the active-low asynchronous reset.
`timescale 1ns/10ps
module pmu_alarm_regs_asserts (
    input wire logic                     clk_sys,
    input wire logic                     reset_n,
    input wire pmu_pkg::pmu_spi_in_t     spi_in,
    input wire logic                     sdo_oe,
    input wire logic [7:0]               temp_celsius,
    input wire logic                     alarm_o,
    input wire logic                     alarm_oe,
    input wire pmu_pkg::pmu_ctrl_t [1:0] unit_ctrl,
    input wire logic [1:0]               meas_out_oe,
    input wire logic [1:0]               meas_out_temp_sel,
    input wire logic [1:0]               voltage_clamp_on
);
    import pmu_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Frame deselected long enough for the synchroniser to settle
    sequence cs_idle;
        spi_in.cs_n [*7];
    endsequence
    // No frame and a cold sensor, so only a latched source can hold the pin
    sequence quiet;
        (spi_in.cs_n && temp_celsius == 8'h00) [*7];
    endsequence
    temp_route_a: assert property (
        meas_out_temp_sel == {unit_ctrl[1][14], unit_ctrl[0][14]})
        else $error("measure-out source differs from control bit 14");
    meas_drive_a: assert property (
        meas_out_oe == {unit_ctrl[1][13], unit_ctrl[0][13]})
        else $error("measure-out enable differs from control bit 13");
    clamp_route_a: assert property (
        voltage_clamp_on == {unit_ctrl[1][10], unit_ctrl[0][10]})
        else $error("voltage clamp enable differs from control bit 10");
    rsvd_zero_a: assert property (
        unit_ctrl[0][12:11] == 2'b00 && unit_ctrl[1][12:11] == 2'b00)
        else $error("reserved control bits not zero");
    drain_only_a: assert property (
        alarm_o == 1'b0)
        else $error("fault pin driven high");
    sdo_idle_a: assert property (
        cs_idle |-> !sdo_oe)
        else $error("serial output driven outside a frame");
    sdo_active_a: assert property (
        (!spi_in.cs_n) [*7] |-> sdo_oe)
        else $error("serial output not driven inside a frame");
    sdo_reset_a: assert property (
        ($rose(reset_n) && spi_in.cs_n) |-> (!sdo_oe) [*6])
        else $error("serial output driven right after reset");
    ctrl_hold_a: assert property (
        cs_idle |-> $stable(unit_ctrl))
        else $error("control outputs moved without a frame");
    alarm_hold_a: assert property (
        quiet ##0 alarm_oe |=> alarm_oe)
        else $error("latched fault released without a clearing write");
endmodule

// >>> dv/pmu_host_model.sv
// Host controller model driving the serial programming port frame by frame.
// Assumes clk_sys is the device clock; every pin change lands on its rising edge.
`timescale 1ns/10ps
module pmu_host_model (
    input  wire logic            clk_sys,
    input  wire logic            sdo_o,
    output pmu_pkg::pmu_spi_in_t spi_in
);
    import pmu_pkg::*;
    localparam int HALF = 6; // Clocks per sclk phase; at least six so read data settles
    // Idle pins: deselected, serial clock parked low
    initial spi_in = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
    // One 26-bit frame; read bits are gathered before each rise from index 10 on
    task automatic xfer(input logic rd, input logic [1:0] ch, input logic [4:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata);
        logic [25:0] f;
        f = {rd, ch[0], ch[1], addr, 2'b00, wdata};
        rdata = 16'h0000;
        @(posedge clk_sys);
        spi_in.cs_n <= 1'b0;
        for (int i = 0; i < 26; i++) begin
            spi_in.sdi <= f[25-i];
            repeat (HALF) @(posedge clk_sys);
            if (i >= 10) begin
                rdata = {rdata[14:0], sdo_o};
            end
            spi_in.sclk <= 1'b1;
            repeat (HALF) @(posedge clk_sys);
            spi_in.sclk <= 1'b0;
        end
        // Released data line shows the inverse, never a stale copy
        spi_in.sdi <= ~f[0];
        repeat (HALF) @(posedge clk_sys);
        spi_in.cs_n <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the measurement unit register bank.
// Assumes the host model alone drives the serial pins; analog flags come from here.
`timescale 1ns/10ps
module testbench;
    import pmu_pkg::*;
    localparam logic [31:0] CODE = 32'h5a5a_c3c3; // Arbitrary serialization value
    logic                clk_sys = 1'b0;
    logic                reset_n = 1'b0;
    pmu_spi_in_t         spi_in;
    logic                sdo_o;
    logic                sdo_oe;
    logic [7:0]          temp_celsius = 8'd20;
    logic [1:0]          clamp_engaged = 2'b00;
    logic [1:0]          overvoltage_fault = 2'b00;
    logic                alarm_o;
    logic                alarm_oe;
    pmu_ctrl_t [1:0]     unit_ctrl;
    logic [1:0]          meas_out_oe;
    logic [1:0]          meas_out_temp_sel;
    logic [1:0]          voltage_clamp_on;
    int                  n_fail = 0;
    int                  comparisons = 0;
    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;
    pmu_alarm_regs #(.SERIAL_CODE(CODE)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .spi_in(spi_in), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .temp_celsius(temp_celsius), .clamp_engaged(clamp_engaged),
        .overvoltage_fault(overvoltage_fault), .alarm_o(alarm_o), .alarm_oe(alarm_oe),
        .unit_ctrl(unit_ctrl), .meas_out_oe(meas_out_oe),
        .meas_out_temp_sel(meas_out_temp_sel), .voltage_clamp_on(voltage_clamp_on));
    pmu_host_model u_host (.clk_sys(clk_sys), .sdo_o(sdo_o), .spi_in(spi_in));
    // Compare and count; four-state equality so unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] ch, input logic [4:0] a, input logic [15:0] d);
        logic [15:0] r;
        u_host.xfer(1'b0, ch, a, d, r);
    endtask
    task automatic rd(input logic [1:0] ch, input logic [4:0] a, output logic [15:0] r);
        u_host.xfer(1'b1, ch, a, 16'h0000, r);
    endtask
    // Raise fault flags for eight cycles, drop them, then judge the fault pin
    task automatic stim(input logic [7:0] t, input logic [1:0] c, input logic [1:0] o,
                        input logic exp);
        temp_celsius <= t;
        clamp_engaged <= c;
        overvoltage_fault <= o;
        repeat (8) @(posedge clk_sys);
        clamp_engaged <= 2'b00;
        overvoltage_fault <= 2'b00;
        repeat (8) @(posedge clk_sys);
        chk({15'h0, alarm_oe}, {15'h0, exp});
    endtask
    task automatic t_reset();
        logic [15:0] r;
        chk(unit_ctrl[0], 16'h0000);
        chk(unit_ctrl[1], 16'h0000);
        rd(2'b10, PMU_ADDR_CTRL, r);
        chk(r, 16'h0000);
        rd(2'b01, PMU_ADDR_ALARM, r);
        chk(r, 16'h0085);
        rd(2'b10, PMU_ADDR_ALARM, r);
        chk(r, 16'h0085);
    endtask
    // Every control field, every current range; channel 1 untouched by channel 0 writes
    task automatic t_ctrl();
        logic [15:0] r;
        logic [15:0] v [16] = '{16'h4000, 16'h2000, 16'h0400, 16'h0200, 16'h0180,
            16'h0080, 16'h0100, 16'h0040, 16'h0020, 16'h000c, 16'h0010, 16'h0014,
            16'h0018, 16'h001c, 16'h0002, 16'h0001};
        wr(2'b01, PMU_ADDR_CTRL, 16'hffff);
        chk(unit_ctrl[0], 16'he7ff);
        chk(unit_ctrl[1], 16'h0000);
        chk({13'h0, meas_out_oe[0], meas_out_temp_sel[0], voltage_clamp_on[0]}, 16'h0007);
        rd(2'b01, PMU_ADDR_CTRL, r);
        chk(r, 16'he7ff);
        foreach (v[i]) begin
            wr(2'b10, PMU_ADDR_CTRL, v[i]);
            chk(unit_ctrl[1], v[i]);
            rd(2'b10, PMU_ADDR_CTRL, r);
            chk(r, v[i]);
        end
        // One frame addressing both channels
        wr(2'b11, PMU_ADDR_CTRL, 16'h2401);
        chk(unit_ctrl[0], 16'h2401);
        chk(unit_ctrl[1], 16'h2401);
        chk({14'h0, meas_out_oe}, 16'h0003);
        chk({14'h0, meas_out_temp_sel}, 16'h0000);
        chk({14'h0, voltage_clamp_on}, 16'h0003);
    endtask
    task automatic t_serial();
        logic [15:0] r;
        rd(2'b01, PMU_ADDR_SERIAL, r);
        chk(r, CODE[15:0]);
        wr(2'b10, PMU_ADDR_SERIAL, 16'h0000);
        rd(2'b10, PMU_ADDR_SERIAL, r);
        chk(r, CODE[31:16]);
        rd(2'b01, 5'h00, r);
        chk(r, 16'h0000);
    endtask
    task automatic t_alarm();
        logic [15:0] r;
        stim(8'd90, 2'b00, 2'b00, 1'b0);
        stim(8'd110, 2'b00, 2'b00, 1'b1);
        wr(2'b01, PMU_ADDR_ALARM, 16'h00a5);
        stim(8'd120, 2'b00, 2'b00, 1'b0);
        stim(8'd130, 2'b00, 2'b00, 1'b1);
        wr(2'b01, PMU_ADDR_ALARM, 16'h00ad);
        stim(8'd130, 2'b01, 2'b00, 1'b0);
        wr(2'b01, PMU_ADDR_ALARM, 16'h00a1);
        stim(8'd20, 2'b01, 2'b00, 1'b1);
        wr(2'b01, PMU_ADDR_ALARM, 16'h00a1);
        stim(8'd20, 2'b00, 2'b00, 1'b0);
        wr(2'b10, PMU_ADDR_ALARM, 16'hffff);
        rd(2'b10, PMU_ADDR_ALARM, r);
        chk(r, 16'h00ed);
        stim(8'd20, 2'b00, 2'b10, 1'b0);
        wr(2'b10, PMU_ADDR_ALARM, 16'h0084);
        stim(8'd0, 2'b00, 2'b10, 1'b1);
        wr(2'b10, PMU_ADDR_ALARM, 16'h0085);
        stim(8'd20, 2'b00, 2'b00, 1'b0);
        // Top threshold code and the 50 degree code, at the threshold and one degree above
        wr(2'b01, PMU_ADDR_ALARM, 16'h00e1);
        stim(8'd150, 2'b00, 2'b00, 1'b0);
        stim(8'd151, 2'b00, 2'b00, 1'b1);
        wr(2'b01, PMU_ADDR_ALARM, 16'h0045);
        stim(8'd50, 2'b00, 2'b00, 1'b0);
        stim(8'd51, 2'b00, 2'b00, 1'b1);
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence: reset for four cycles, let synchronisers settle, run scenarios
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        t_reset();
        t_ctrl();
        t_serial();
        t_alarm();
        end_sim();
    end
    // Watchdog: about 17k cycles expected, so 80k means a hang
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end
endmodule
bind pmu_alarm_regs pmu_alarm_regs_asserts u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .spi_in(spi_in), .sdo_oe(sdo_oe),
    .temp_celsius(temp_celsius), .alarm_o(alarm_o), .alarm_oe(alarm_oe),
    .unit_ctrl(unit_ctrl), .meas_out_oe(meas_out_oe),
    .meas_out_temp_sel(meas_out_temp_sel), .voltage_clamp_on(voltage_clamp_on));
